// ### verilog/raf_consts.vh
// Purpose: Constants for the reading average filter and speed control block.
// Assumes: 25 MHz mclk, APB register access, 32-bit data.
// Notes: Integration time is held in hundredths of a line cycle.
// How it works
// RL1: Output reading is the mean of 1 to 100 conversions.
// RL2: Repeating mode fills the set, emits its mean, then restarts empty.
// RL3: Averaging type resets to repeating.
// RL4: Moving mode keeps a FIFO of count conversions, oldest replaced, new mean each time.
// RL5: First conversion after enable fills every slot, so first output equals it; repeating mode with count above 1 emits the set mean instead.
// RL6: Moving mode keeps averaging; copies are replaced one at a time.
// RL7: Toggle request flips averaging; active indicator follows the enable.
// RL8: One filter type and count serve all functions.
// RL9: Enable refused in pulse mode, invalid-in-pulse flag raised.
// RL10: Integration time 0.01 to 10 cycles accepted; resolution untouched.
// RL11: Presets set time and digits: 1/4, 10/5, 100/6, 1000/7 hundredths/setting.
// RL12: Integration time resets to one cycle, the normal preset.
// RL13: One cycle lasts 16.67 ms at 60 Hz, 20 ms at 50 or 400 Hz.
// RL14: Pulse mode accepts only 0.01 to 0.10 cycles, rejects the rest.
// RL15: Pulse mode time changes leave resolution alone.
// RL16: One time value for all functions, also stored per source-memory step.
// RL17: Resolution accepts only 4, 5, 6 or 7.
// RL18: Current, voltage and resistance each hold a manual range and auto flag.
// RL19: Pulse mode rejects auto-range flag changes.
// RL20: Presets change resolution; resolution writes never change time.
// RL21: Type and count are programmable from software.
// RL22: Mean is sum over count with an accumulator that cannot overflow.
// RL23: Changing type or count while enabled empties the store.
`ifndef RAF_CONSTS_VH
`define RAF_CONSTS_VH
`define RAF_A_CTRL     8'h00
`define RAF_A_FCFG     8'h04
`define RAF_A_TIME     8'h08
`define RAF_A_PRESET   8'h0C
`define RAF_A_DIGITS   8'h10
`define RAF_A_RANGE    8'h14
`define RAF_A_STATUS   8'h18
`define RAF_A_RESULT   8'h1C
`define RAF_A_SRCMEM   8'h20
`define RAF_A_CYCLE    8'h24
`define RAF_CNT_MIN    7'h01
`define RAF_CNT_MAX    7'h64
`define RAF_T_MIN      10'h001
`define RAF_T_MAX      10'h3E8
`define RAF_T_PMAX     10'h00A
`define RAF_T_NORMAL   10'h064
`define RAF_T_MED      10'h00A
`define RAF_D_MIN      3'h4
`define RAF_D_MAX      3'h7
`define RAF_D_NORMAL   3'h6
`define RAF_TYPE_REP   1'b0
`define RAF_TYPE_MOV   1'b1
`define RAF_US60       32'h0000411E
`define RAF_US50       32'h00004E20
`define RAF_MHZ        32'h00000019
`define RAF_T_SCALE    32'h00000064
`define RAF_SRC_DEPTH  16
`endif

// ### verilog/raf_filter.v
// Purpose: Averaging filter, integration time, digits and range settings with APB access.
// Assumes: Conversions arrive as signed 24-bit words with a one-cycle strobe.
// Notes: The mean is computed by a sequential divider, one quotient bit per clock.
`timescale 1ns/1ns
`default_nettype none
`include "raf_consts.vh"
module raf_filter (
  input  wire        mclk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        conv_valid,
  input  wire [23:0] conv_data,
  input  wire        pulse_mode_pin,
  input  wire        line_60hz_pin,
  input  wire [3:0]  src_step,
  output reg         rdg_valid,
  output reg  [23:0] rdg_data,
  output reg         averaging_active_indicator,
  output reg  [9:0]  integration_line_cycles,
  output reg  [31:0] integ_cycles_clk,
  output reg  [2:0]  disp_digits
);
  // Settings live in one register set shared by every measurement function;
  // the filter store, running sum and divider form the reading datapath.
  // A reading costs one pass of a 32-step restoring divider, which is why
  // conversions must be spaced further apart than the divider takes.
  reg        pm_s1_q, pm_q, lf_s1_q, lf_q;
  reg        en_q, type_q, inval_q, bad_q;
  reg [6:0]  count_q;
  reg [9:0]  time_q;
  reg [2:0]  digits_q;
  reg [7:0]  rng_i_q, rng_v_q, rng_r_q;
  reg [2:0]  auto_q;
  reg [9:0]  srcmem [0:`RAF_SRC_DEPTH-1];
  reg [9:0]  step_time;
  reg [23:0] store [0:99];
  reg [6:0]  wr_q, fill_q;
  reg        empty_q;
  reg signed [31:0] sum_q;
  reg        div_busy_q;
  reg [4:0]  div_bit_q;
  reg [31:0] div_num_q, div_quo_q;
  reg [38:0] div_rem_q;
  reg        div_neg_q;
  reg        c_v_q;
  reg [23:0] c_d_q;
  reg [23:0] old_w;
  reg [38:0] rem_try;
  wire       wr_acc = psel & penable & pwrite;
  // Reads are latched in the setup cycle, so prdata already stands when the
  // access cycle brings pready; a registered answer one edge later would be
  // missed by a master that takes the data at the pready edge.
  wire       rd_acc = psel & ~penable & ~pwrite;
  integer    k;
  integer    j;

  // Combinational taps: the slot about to be replaced and the next divider step.
  always @* begin
    old_w   = store[wr_q];
    rem_try = {div_rem_q[37:0], div_num_q[div_bit_q]};
  end

  // The slave never flags a bad address, so an unmapped read simply
  // returns zero and an unmapped write is dropped.
  function legal_addr;
    input [7:0] a;
    begin
      legal_addr = (a == `RAF_A_CTRL) | (a == `RAF_A_FCFG) | (a == `RAF_A_TIME)
                 | (a == `RAF_A_PRESET) | (a == `RAF_A_DIGITS) | (a == `RAF_A_RANGE)
                 | (a == `RAF_A_STATUS) | (a == `RAF_A_RESULT)
                 | (a[7:6] == 2'b10) | (a == `RAF_A_CYCLE);
    end
  endfunction

  // Legal time in hundredths of a cycle; pulse mode narrows the window.
  function time_ok;
    input [9:0] t;
    input       pm;
    begin
      time_ok = (t >= `RAF_T_MIN) & (t <= (pm ? `RAF_T_PMAX : `RAF_T_MAX)); // RL10 RL14
    end
  endfunction

  // Pin levels come from another domain, so both pins pass two flops.
  // Both are slow levels, so the two edges of delay cost nothing.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pm_s1_q <= 1'b0;
      pm_q    <= 1'b0;
      lf_s1_q <= 1'b0;
      lf_q    <= 1'b0;
    end else begin
      pm_s1_q <= pulse_mode_pin;
      pm_q    <= pm_s1_q;
      lf_s1_q <= line_60hz_pin;
      lf_q    <= lf_s1_q;
    end
  end

  // Per-step times for sweeps. They clear at reset, so a step that was never
  // written holds zero and the shared time applies to it.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (j = 0; j < `RAF_SRC_DEPTH; j = j + 1)
        srcmem[j] <= 10'h000;
      step_time <= 10'h000;
    end else begin
      if (wr_acc && pready && paddr[7:6] == 2'b10 && time_ok(pwdata[9:0], pm_q))
        srcmem[paddr[5:2]] <= pwdata[9:0]; // RL16
      step_time <= srcmem[src_step];
    end
  end

  // Settings registers and APB slave.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      en_q     <= 1'b0;
      type_q   <= `RAF_TYPE_REP; // RL3
      count_q  <= `RAF_CNT_MIN;
      time_q   <= `RAF_T_NORMAL; // RL12
      digits_q <= `RAF_D_NORMAL;
      rng_i_q  <= 8'h00;
      rng_v_q  <= 8'h00;
      rng_r_q  <= 8'h00;
      auto_q   <= 3'h0;
      inval_q  <= 1'b0;
      bad_q    <= 1'b0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h00000000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      // Entering pulse mode drops averaging at once rather than waiting for
      // a toggle, since the filter may not run there at all.
      if (pm_q && en_q)
        en_q <= 1'b0; // RL9
      if (wr_acc && pready) begin
        if (!legal_addr(paddr))
          pslverr <= 1'b0;
        case (paddr)
          `RAF_A_CTRL: begin
            // The clear comes first so that a refused enable in the same
            // write still leaves the flag set.
            if (pwdata[1])
              inval_q <= 1'b0;
            if (pwdata[0]) begin
              if (pm_q && !en_q)
                inval_q <= 1'b1; // RL9
              else
                en_q <= ~en_q; // RL7
            end
            if (pwdata[2])
              bad_q <= 1'b0;
          end
          `RAF_A_FCFG: begin
            // One shared copy serves every measurement function.
            type_q <= pwdata[8]; // RL8 RL21
            if (pwdata[6:0] >= `RAF_CNT_MIN && pwdata[6:0] <= `RAF_CNT_MAX)
              count_q <= pwdata[6:0]; // RL1 RL21
            else
              bad_q <= 1'b1;
          end
          `RAF_A_TIME: begin
            if (time_ok(pwdata[9:0], pm_q))
              time_q <= pwdata[9:0]; // RL10 RL14 RL15
            else
              bad_q <= 1'b1;
          end
          `RAF_A_PRESET: begin
            // Presets carry a resolution, which pulse mode must not touch.
            if (pm_q)
              bad_q <= 1'b1;
            else begin
              case (pwdata[1:0]) // RL11 RL20
                2'h0: begin
                  time_q   <= `RAF_T_MIN;
                  digits_q <= `RAF_D_MIN;
                end
                2'h1: begin
                  time_q   <= `RAF_T_MED;
                  digits_q <= 3'h5;
                end
                2'h2: begin
                  time_q   <= `RAF_T_NORMAL;
                  digits_q <= `RAF_D_NORMAL;
                end
                default: begin
                  time_q   <= `RAF_T_MAX;
                  digits_q <= `RAF_D_MAX;
                end
              endcase
            end
          end
          `RAF_A_DIGITS: begin
            if (pwdata[2:0] >= `RAF_D_MIN && pwdata[2:0] <= `RAF_D_MAX)
              digits_q <= pwdata[2:0]; // RL17 RL20
            else
              bad_q <= 1'b1;
          end
          `RAF_A_RANGE: begin
            rng_i_q <= pwdata[7:0]; // RL18
            rng_v_q <= pwdata[15:8];
            rng_r_q <= pwdata[23:16];
            // Rewriting the same auto flags in pulse mode is harmless and
            // accepted; only a change is refused.
            if (pm_q && pwdata[26:24] != auto_q)
              bad_q <= 1'b1; // RL19
            else
              auto_q <= pwdata[26:24];
          end
          default: begin
          end
        endcase
      end
      if (rd_acc) begin
        case (paddr)
          `RAF_A_CTRL:   prdata <= {31'h00000000, en_q};
          `RAF_A_FCFG:   prdata <= {23'h000000, type_q, 1'b0, count_q};
          `RAF_A_TIME:   prdata <= {22'h000000, time_q};
          `RAF_A_DIGITS: prdata <= {29'h00000000, digits_q};
          `RAF_A_RANGE:  prdata <= {5'h00, auto_q, rng_r_q, rng_v_q, rng_i_q};
          `RAF_A_STATUS: prdata <= {27'h0000000, lf_q, pm_q, bad_q, inval_q, en_q};
          `RAF_A_RESULT: prdata <= {{8{rdg_data[23]}}, rdg_data};
          `RAF_A_CYCLE:  prdata <= integ_cycles_clk;
          default:       prdata <= (paddr[7:6] == 2'b10) ? {22'h000000, srcmem[paddr[5:2]]}
                                                         : 32'h00000000;
        endcase
      end
    end
  end

  // Integration period in clocks: time/100 cycles of 16.67 or 20 ms.
  // The product is formed before the division by one hundred so that the
  // half clock in each hundredth of a 60 Hz cycle is not lost; at the longest time the
  // product still fits in 32 bits.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      integration_line_cycles    <= `RAF_T_NORMAL;
      integ_cycles_clk           <= 32'h00000000;
      disp_digits                <= `RAF_D_NORMAL;
      averaging_active_indicator <= 1'b0;
    end else begin
      integration_line_cycles    <= (step_time != 10'h000) ? step_time : time_q; // RL16
      integ_cycles_clk           <= (lf_q ? `RAF_US60 : `RAF_US50) * `RAF_MHZ
                                    * {22'h000000, integration_line_cycles}
                                    / `RAF_T_SCALE; // RL13
      disp_digits                <= digits_q;
      averaging_active_indicator <= en_q; // RL7
    end
  end

  // Filter datapath: store update and running sum.
  // The store is not reset; the first conversion after the store empties
  // writes every slot before any slot is read.
  always @(posedge mclk) begin
    if (c_v_q) begin
      if (empty_q) begin
        for (k = 0; k < 100; k = k + 1)
          store[k] <= c_d_q; // RL5
      end else
        store[wr_q] <= c_d_q; // RL4 RL6
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      c_v_q      <= 1'b0;
      c_d_q      <= 24'h000000;
      wr_q       <= 7'h00;
      fill_q     <= 7'h00;
      empty_q    <= 1'b1;
      sum_q      <= 32'sh00000000;
      div_busy_q <= 1'b0;
      div_bit_q  <= 5'h00;
      div_num_q  <= 32'h00000000;
      div_quo_q  <= 32'h00000000;
      div_rem_q  <= 39'h0000000000;
      div_neg_q  <= 1'b0;
      rdg_valid  <= 1'b0;
      rdg_data   <= 24'h000000;
    end else begin
      c_v_q     <= conv_valid & en_q;
      c_d_q     <= conv_data;
      rdg_valid <= 1'b0;
      if (!en_q || (wr_acc && pready && paddr == `RAF_A_FCFG)) begin
        empty_q <= 1'b1; // RL23
        wr_q    <= 7'h00;
        fill_q  <= 7'h00;
        sum_q   <= 32'sh00000000;
        // A division in flight belongs to the old settings and is dropped.
        div_busy_q <= 1'b0;
      end else if (c_v_q) begin
        // 24-bit words times 100 fit in 31 bits, so the sum never wraps.
        // An empty store takes the conversion into every slot at once, so
        // the running sum starts as that value times the count.
        if (empty_q) begin
          sum_q   <= $signed({{8{c_d_q[23]}}, c_d_q}) * $signed({25'h0000000, count_q}); // RL22
          empty_q <= 1'b0;
          wr_q    <= (count_q == `RAF_CNT_MIN) ? 7'h00 : 7'h01;
          fill_q  <= 7'h01;
          if (type_q == `RAF_TYPE_MOV || count_q == `RAF_CNT_MIN) begin
            div_busy_q <= 1'b1;
            div_bit_q  <= 5'h1F;
            div_num_q  <= c_d_q[23] ? -({{8{c_d_q[23]}}, c_d_q} * {25'h0000000, count_q})
                                    : {8'h00, c_d_q} * {25'h0000000, count_q};
            div_neg_q  <= c_d_q[23];
            div_rem_q  <= 39'h0000000000;
          end
        end else begin
          // Moving mode answers on every conversion; repeating mode only
          // when the set is complete, and then starts the next set empty.
          sum_q  <= sum_q - $signed({{8{old_w[23]}}, old_w})
                          + $signed({{8{c_d_q[23]}}, c_d_q});
          wr_q   <= (wr_q + 7'h01 >= count_q) ? 7'h00 : wr_q + 7'h01;
          fill_q <= (fill_q + 7'h01 >= count_q) ? 7'h00 : fill_q + 7'h01;
          if (type_q == `RAF_TYPE_MOV || fill_q + 7'h01 >= count_q)
            div_busy_q <= 1'b1; // RL2 RL4
          if (type_q == `RAF_TYPE_REP && fill_q + 7'h01 >= count_q)
            empty_q <= 1'b1; // RL2
          div_bit_q <= 5'h1F;
          div_rem_q <= 39'h0000000000;
        end
      end else if (div_busy_q) begin
        // One quotient bit per edge, most significant first, on the
        // magnitude; the sign is put back when the last bit is known.
        if (div_bit_q == 5'h1F && div_quo_q == 32'hFFFFFFFF) begin
          div_quo_q <= 32'h00000000;
        end
        if (rem_try >= {32'h00000000, count_q}) begin
          div_rem_q            <= rem_try - {32'h00000000, count_q};
          div_quo_q[div_bit_q] <= 1'b1; // RL22
        end else begin
          div_rem_q            <= rem_try;
          div_quo_q[div_bit_q] <= 1'b0;
        end
        div_bit_q <= div_bit_q - 5'h01;
        if (div_bit_q == 5'h00) begin
          div_busy_q <= 1'b0;
          // The mean is truncated toward zero for either sign.
          rdg_valid  <= 1'b1; // RL1
          rdg_data   <= div_neg_q ? -{div_quo_q[23:1], rem_try >= {32'h00000000, count_q}}
                                  : {div_quo_q[23:1], rem_try >= {32'h00000000, count_q}};
        end
      end
      // The divider takes the magnitude of the sum that the branch above
      // stores, so the reading and the sum never disagree.
      if (c_v_q && !empty_q && en_q) begin
        div_num_q <= (sum_q - $signed({{8{old_w[23]}}, old_w})
                     + $signed({{8{c_d_q[23]}}, c_d_q})) < 0
                     ? -(sum_q - $signed({{8{old_w[23]}}, old_w}) + $signed({{8{c_d_q[23]}}, c_d_q}))
                     : (sum_q - $signed({{8{old_w[23]}}, old_w}) + $signed({{8{c_d_q[23]}}, c_d_q}));
        div_neg_q <= (sum_q - $signed({{8{old_w[23]}}, old_w})
                     + $signed({{8{c_d_q[23]}}, c_d_q})) < 0;
      end
    end
  end
endmodule // raf_filter
`default_nettype wire

// ### verif/raf_filter_chk.sv
// Purpose: Port checker for the averaging filter block.
// Assumes: No APB wait state and a reading 34 clocks after its conversion.
// Notes: Bound to the design from the bench top file.
`timescale 1ns/1ns
`default_nettype none
module raf_filter_chk (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       conv_valid,
  input wire logic       rdg_valid,
  input wire logic       averaging_active_indicator,
  input wire logic [9:0] integration_line_cycles,
  input wire logic [2:0] disp_digits
);
  wire ctl_wr = psel && penable && pready && pwrite && (paddr == 8'h00);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_setup; psel && !penable && !pready; endsequence
  sequence s_done; psel && penable && pready; endsequence
  property p_apb; s_setup |=> s_done; endproperty
  a_apb: assert property (p_apb) else $error("APB answer not in first access cycle");
  property p_rst;
    $fell(rst) |-> integration_line_cycles == 10'h064 && disp_digits == 3'h6
      && !averaging_active_indicator;
  endproperty
  a_rst: assert property (p_rst) else $error("bad values after reset");
  property p_lat; $rose(rdg_valid) |-> $past(conv_valid, 34); endproperty
  a_lat: assert property (p_lat) else $error("reading without conversion");
  property p_pulse; rdg_valid |=> !rdg_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("reading strobe too long");
  property p_off; conv_valid && !averaging_active_indicator |-> ##34 !rdg_valid; endproperty
  a_off: assert property (p_off) else $error("reading while disabled");
  property p_rise; $rose(averaging_active_indicator) |-> $past(ctl_wr) || $past(ctl_wr, 2);
  endproperty
  a_rise: assert property (p_rise) else $error("indicator rose untold");
  property p_err; pslverr == 1'b0; endproperty
  a_err: assert property (p_err) else $error("unexpected slave error");
  property p_dig; disp_digits inside {[3'h4:3'h7]}; endproperty
  a_dig: assert property (p_dig) else $error("digits out of range");
  property p_time; integration_line_cycles inside {[10'h001:10'h3E8]}; endproperty
  a_time: assert property (p_time) else $error("time out of range");
  property p_dtime;
    s_done ##0 (pwrite && paddr == 8'h10) |=> $stable(integration_line_cycles) [*3];
  endproperty
  a_dtime: assert property (p_dtime) else $error("digits write moved time");
endmodule // raf_filter_chk
`default_nettype wire

// ### verif/raf_adc_model.sv
// Purpose: Converter model that hands one conversion per request.
// Assumes: Requests are spaced well beyond the filter latency.
// Notes: Data lines toggle outside the strobe so stale values are never trusted.
`timescale 1ns/1ns
`default_nettype none
module raf_adc_model (
  input  wire logic        mclk,
  input  wire logic        req,
  input  wire logic        slow,
  input  wire logic [23:0] val,
  output var  logic        conv_valid,
  output var  logic [23:0] conv_data
);
  logic [3:0] wait_q;
  logic       busy_q;
  initial begin
    busy_q = 1'b0;
    wait_q = 4'h0;
    conv_valid = 1'b0;
    conv_data = 24'h0;
  end
  always @(posedge mclk) begin
    conv_valid <= 1'b0;
    conv_data <= ~conv_data;
    if (req) begin
      busy_q <= 1'b1;
      wait_q <= slow ? 4'h5 : 4'h0;
    end else if (busy_q && wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end else if (busy_q) begin
      busy_q <= 1'b0;
      conv_valid <= 1'b1;
      conv_data <= val;
    end
  end
endmodule // raf_adc_model
`default_nettype wire

// ### verif/raf_filter_tb.sv
// Purpose: Self-checking bench for the averaging filter block.
// Assumes: Tasks are entered just after a rising edge.
// Notes: Source memory step leaves zero for one check only.
`timescale 1ns/1ns
`default_nettype none
`include "raf_consts.vh"
module raf_filter_tb;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, req, slow;
  logic        conv_valid, pulse_mode_pin, line_60hz_pin, rdg_valid, averaging_active_indicator;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, integ_cycles_clk;
  logic [23:0] conv_data, val, rdg_data;
  logic [9:0]  integration_line_cycles;
  logic [2:0]  disp_digits;
  logic [3:0]  src_step;
  int          error_cnt, total_checks, cyc, i;
  logic [23:0] mv_in [5] = '{24'h8, 24'hC, 24'h10, 24'h14, 24'h18};
  logic [23:0] mv_ex [5] = '{24'h8, 24'h9, 24'hB, 24'hE, 24'h12};
  logic [9:0]  pt [4] = '{10'h1, 10'hA, 10'h64, 10'h3E8};
  raf_filter DUT (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .conv_valid, .conv_data, .pulse_mode_pin, .line_60hz_pin, .src_step,
    .rdg_valid, .rdg_data, .averaging_active_indicator, .integration_line_cycles,
    .integ_cycles_clk, .disp_digits);
  raf_adc_model u_adc (.mclk, .req, .slow, .val, .conv_valid, .conv_data);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // Settings reach the ports one edge after the write lands; the extra edge
  // lets a check that follows see them.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(posedge mclk);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask
  // Waits longer than the reading latency, which also spaces conversions.
  task automatic conv(input logic [23:0] v, input logic s, ex, input logic [23:0] e);
    logic got;
    got = 1'b0;
    val <= v;
    slow <= s;
    req <= 1'b1;
    @(posedge mclk);
    req <= 1'b0;
    repeat (45) begin
      @(posedge mclk);
      if (rdg_valid === 1'b1) begin
        got = 1'b1;
        chk("rdg_data", {8'h0, e}, {8'h0, rdg_data});
      end
    end
    chk("rdg_valid", {31'h0, ex}, {31'h0, got});
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, req, slow, val} = {1'b1, 69'h0};
    {pulse_mode_pin, line_60hz_pin, src_step, error_cnt, total_checks, cyc} = {2'b01, 100'h0};
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk("time", 32'h64, {22'h0, integration_line_cycles});
    chk("digits", 32'h6, {29'h0, disp_digits});
    rdc("type", `RAF_A_FCFG, 32'h100, 32'h0);
    conv(24'h55, 1'b0, 1'b0, 24'h0);
    wr(`RAF_A_FCFG, 32'h3);
    wr(`RAF_A_CTRL, 32'h1);
    conv(24'hA, 1'b0, 1'b0, 24'h0);
    conv(24'h14, 1'b1, 1'b0, 24'h0);
    conv(24'h21, 1'b0, 1'b1, 24'h15);
    conv(24'h3, 1'b0, 1'b0, 24'h0);
    conv(24'h3, 1'b0, 1'b0, 24'h0);
    conv(24'h6, 1'b1, 1'b1, 24'h4);
    chk("active", 32'h1, {31'h0, averaging_active_indicator});
    wr(`RAF_A_FCFG, 32'h104);
    for (i = 0; i < 5; i++) conv(mv_in[i], i[0], 1'b1, mv_ex[i]);
    wr(`RAF_A_FCFG, 32'h102);
    conv(24'h20, 1'b0, 1'b1, 24'h20);
    wr(`RAF_A_FCFG, 32'h64);
    for (i = 0; i < 99; i++) conv(24'h7FFFFF, 1'b0, 1'b0, 24'h0);
    conv(24'h7FFFFF, 1'b0, 1'b1, 24'h7FFFFF);
    wr(`RAF_A_FCFG, 32'h65);
    wr(`RAF_A_FCFG, 32'h0);
    rdc("count", `RAF_A_FCFG, 32'h17F, 32'h64);
    rdc("bad", `RAF_A_STATUS, 32'h4, 32'h4);
    wr(`RAF_A_CTRL, 32'h5);
    chk("active", 32'h0, {31'h0, averaging_active_indicator});
    for (i = 0; i < 4; i++) begin
      wr(`RAF_A_PRESET, 32'(i));
      chk("time", {22'h0, pt[i]}, {22'h0, integration_line_cycles});
      chk("digits", 32'(i + 4), {29'h0, disp_digits});
    end
    wr(`RAF_A_TIME, 32'hFA);
    chk("digits", 32'h7, {29'h0, disp_digits});
    wr(`RAF_A_DIGITS, 32'h5);
    wr(`RAF_A_DIGITS, 32'h3);
    wr(`RAF_A_DIGITS, 32'h8);
    chk("digits", 32'h5, {29'h0, disp_digits});
    wr(`RAF_A_TIME, 32'h0);
    wr(`RAF_A_TIME, 32'h3E9);
    chk("time", 32'hFA, {22'h0, integration_line_cycles});
    wr(8'h84, 32'h32);
    src_step <= 4'h1;
    repeat (3) @(posedge mclk);
    chk("steptime", 32'h32, {22'h0, integration_line_cycles});
    src_step <= 4'h0;
    wr(`RAF_A_TIME, 32'h64);
    repeat (8) @(posedge mclk);
    chk("cycles60", 32'h65BEE, integ_cycles_clk);
    line_60hz_pin <= 1'b0;
    repeat (8) @(posedge mclk);
    chk("cycles50", 32'h7A120, integ_cycles_clk);
    wr(`RAF_A_RANGE, 32'h07030201);
    rdc("range", `RAF_A_RANGE, 32'h07FFFFFF, 32'h07030201);
    pulse_mode_pin <= 1'b1;
    repeat (6) @(posedge mclk);
    wr(`RAF_A_CTRL, 32'h1);
    chk("active", 32'h0, {31'h0, averaging_active_indicator});
    rdc("status", `RAF_A_STATUS, 32'hB, 32'hA);
    wr(`RAF_A_TIME, 32'hB);
    wr(`RAF_A_TIME, 32'h5);
    chk("time", 32'h5, {22'h0, integration_line_cycles});
    chk("digits", 32'h5, {29'h0, disp_digits});
    wr(`RAF_A_RANGE, 32'h00030201);
    rdc("range", `RAF_A_RANGE, 32'h07FFFFFF, 32'h07030201);
    print_verdict();
  end
endmodule // raf_filter_tb
bind raf_filter raf_filter_chk u_chk (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pready,
  .pslverr, .conv_valid, .rdg_valid, .averaging_active_indicator, .integration_line_cycles,
  .disp_digits);
`default_nettype wire
